// *** logic/rtcsa_top.sv ***
// Real-time clock shadow, alarm and status registers behind an APB slave.
// Assumes one 125 MHz clock; the timekeeping tick of 1/256 s is made here.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rtcsa_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Alarm event, one cycle per match
  output logic alarm_pulse
);
  import rtcsa_pkg::*;
  // ==========================================================================
  // State
  rtcsa_time_t counters;
  rtcsa_time_t shadow;
  logic [TICK_DIV_BITS-1:0] div_cnt;
  logic [7:0] subsecond_remaining;
  logic clock_count_failure_flag;
  logic shadow_read_freeze;
  logic write_hold;
  logic alarm_seen;
  logic match_d;
  logic err_inject;
  logic [5:0] alarm_target_minutes;
  logic [4:0] alarm_target_hours;
  logic pending_copy;
  // ==========================================================================
  // Address decode
  wire logic [15:0] idx = paddr[17:2];
  wire logic access = psel && penable;
  wire logic wr = access && pwrite && pstrb[0];
  wire logic [7:0] wb = pwdata[7:0];
  wire logic hit_ctrl = idx == IDX_CTRL;
  wire logic hit_sec = idx == IDX_SEC;
  wire logic hit_min = idx == IDX_MIN;
  wire logic hit_hr = idx == IDX_HR;
  wire logic hit_day = idx == IDX_DAY;
  wire logic hit_date = idx == IDX_DATE;
  wire logic hit_mo = idx == IDX_MO;
  wire logic hit_yr = idx == IDX_YR;
  wire logic hit_time = hit_sec || hit_min || hit_hr || hit_day || hit_date || hit_mo || hit_yr;
  // Unmapped indices answer with an error and never write anything.
  wire logic mapped = hit_ctrl || hit_time || idx == IDX_SUBSEC || idx == IDX_TMIN
    || idx == IDX_THR || idx == IDX_STAT;
  // ==========================================================================
  // Timekeeping tick (256 Hz) and one-second strobe
  wire logic tick = div_cnt == TICK_DIV_BITS'(TICK_DIV - 1);
  wire logic sec_step = tick && subsecond_remaining == 8'h01;
  rtcsa_time_t cal_next;
  logic cal_bad;
  rtcsa_cal u_cal (
    .cur(counters),
    .nxt(cal_next),
    .bad(cal_bad)
  );
  // An out-of-range time is caught only at a second step, and the counters then hold
  // so that the bad value stays visible to software.
  // count error detect
  wire logic count_err = (sec_step && cal_bad) || err_inject;
  // The copy waits for a tick so that a load never lands inside a sub-second step.
  // copy on next tick after hold release
  wire logic do_copy = pending_copy && !write_hold && tick;
  // The comparison uses the running counters, not the shadow, so that a frozen
  // shadow cannot hide a match.
  // hour and minute comparison
  wire logic match_now = counters.mins == alarm_target_minutes
    && counters.hrs == alarm_target_hours;
  // The shadow stops tracking the counters for a freeze request, a held write or a
  // pending copy; software sees all three as a frozen shadow.
  // read-freeze reads back the real shadow status
  wire logic shadow_frozen = shadow_read_freeze || write_hold || pending_copy;
  // ==========================================================================
  // Read mux
  wire logic [7:0] rd_ctrl = {write_hold, shadow_frozen, alarm_seen, clock_count_failure_flag,
    4'h0};
  wire logic [7:0] rd_time = hit_sec ? {2'b00, shadow.sec} :
    hit_min ? {2'b00, shadow.mins} :
    hit_hr ? {3'b000, shadow.hrs} :
    hit_day ? {5'b00000, shadow.day} :
    hit_date ? {3'b000, shadow.date} :
    hit_mo ? {4'h0, shadow.mo} : shadow.yr;
  wire logic [7:0] rd_byte = hit_ctrl ? rd_ctrl :
    idx == IDX_SUBSEC ? subsecond_remaining :
    hit_time ? rd_time :
    idx == IDX_TMIN ? {2'b00, alarm_target_minutes} :
    idx == IDX_THR ? {3'b000, alarm_target_hours} :
    idx == IDX_STAT ? {6'h00, err_inject, match_d} : 8'h00;
  // ==========================================================================
  // APB answer: one wait state, registered outputs.
  // Registering the answer keeps every output on a flop; the price is one wait state
  // on every transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (access && !pwrite && !pready) ? {24'h0, rd_byte} : 32'h0;
      pslverr <= access && !pready && !mapped;
    end
  end
  // Writes take effect at the completing edge only.
  wire logic wr_go = wr && pready && mapped;
  wire logic wr_ctrl = wr_go && hit_ctrl;
  // ==========================================================================
  // Divider and sub-second countdown
  // The divider drops the fraction of the clock over 256, so the second runs slightly
  // fast; trimming against a reference is left to the software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      subsecond_remaining <= 8'h00;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      if (tick) begin
        subsecond_remaining <= subsecond_remaining - 8'h01;
      end
    end
  end
  // ==========================================================================
  // Counters, shadow and control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counters <= RST_TIME;
      shadow <= RST_TIME;
      write_hold <= 1'b0;
      shadow_read_freeze <= 1'b0;
      pending_copy <= 1'b0;
    end else begin
      if (do_copy) begin
        counters <= shadow;
      end else if (sec_step && !cal_bad) begin
        counters <= cal_next;
      end
      if (wr_ctrl) begin
        write_hold <= wb[BIT_WRHOLD];
        shadow_read_freeze <= wb[BIT_RDFRZ];
      end
      // The pending flag keeps the shadow from tracking the counters until the copy
      // has landed, or the time that software wrote would be lost.
      // remember a hold release
      if (wr_ctrl && write_hold && !wb[BIT_WRHOLD]) begin
        pending_copy <= 1'b1;
      end else if (do_copy) begin
        pending_copy <= 1'b0;
      end
      // A time write lands in the shadow only; the counters see it after a copy.
      // software sets the time fields through the shadow
      if (wr_go && hit_time) begin
        if (hit_sec) shadow.sec <= wb[5:0];
        if (hit_min) shadow.mins <= wb[5:0];
        if (hit_hr) shadow.hrs <= wb[4:0];
        if (hit_day) shadow.day <= wb[2:0];
        if (hit_date) shadow.date <= wb[4:0];
        if (hit_mo) shadow.mo <= wb[3:0];
        if (hit_yr) shadow.yr <= wb;
      end else if (!shadow_read_freeze && !write_hold && !pending_copy) begin
        // shadow follows counters only while not frozen
        shadow <= counters;
      end
    end
  end
  // ==========================================================================
  // Flags, targets and alarm event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_count_failure_flag <= 1'b0;
      alarm_seen <= 1'b0;
      match_d <= 1'b0;
      alarm_pulse <= 1'b0;
      err_inject <= 1'b0;
      alarm_target_minutes <= RST_TMIN;
      alarm_target_hours <= RST_THR;
    end else begin
      // A count error in the cycle of a clearing write wins, so no error is lost.
      // set wins over the clear
      if (count_err) begin
        clock_count_failure_flag <= 1'b1;
      end else if (wr_ctrl && !wb[BIT_FAIL]) begin
        clock_count_failure_flag <= 1'b0;
      end
      if (wr_go && idx == IDX_TMIN) alarm_target_minutes <= wb[5:0];
      if (wr_go && idx == IDX_THR) alarm_target_hours <= wb[4:0];
      err_inject <= wr_go && idx == IDX_STAT && wb[BIT_ERRINJ];
      match_d <= match_now;
      // one event on the rising edge of the match
      alarm_pulse <= match_now && !match_d;
      // The sticky alarm bit also lets a new match win over a clearing write.
      if (match_now && !match_d) begin
        alarm_seen <= 1'b1;
      end else if (wr_ctrl && !wb[BIT_ALARM]) begin
        alarm_seen <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/rtcsa_pkg.sv ***
// Package for the real-time clock shadow, alarm and status block.
// Assumes a single APB clock domain; the timekeeping tick is derived inside.
package rtcsa_pkg;
  // ==========================================================================
  // Register map (printed offsets are not all word aligned: these are indices)
  localparam logic [15:0] IDX_CTRL = 16'h2890;
  localparam logic [15:0] IDX_SUBSEC = 16'h2892;
  localparam logic [15:0] IDX_SEC = 16'h2893;
  localparam logic [15:0] IDX_MIN = 16'h2894;
  localparam logic [15:0] IDX_HR = 16'h2895;
  localparam logic [15:0] IDX_DAY = 16'h2896;
  localparam logic [15:0] IDX_DATE = 16'h2897;
  localparam logic [15:0] IDX_MO = 16'h2898;
  localparam logic [15:0] IDX_YR = 16'h2899;
  localparam logic [15:0] IDX_TMIN = 16'h289e;
  localparam logic [15:0] IDX_THR = 16'h289f;
  localparam logic [15:0] IDX_STAT = 16'h28a0;
  // ==========================================================================
  // Control register fields
  localparam int BIT_FAIL = 4;
  localparam int BIT_ALARM = 5;
  localparam int BIT_RDFRZ = 6;
  localparam int BIT_WRHOLD = 7;
  // Status register fields
  localparam int BIT_MATCH = 0;
  localparam int BIT_ERRINJ = 1;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int SUBSEC_HZ = 256;
  localparam int TICK_DIV = CLK_HZ / SUBSEC_HZ;
  localparam int TICK_DIV_BITS = 20;
  // Reset values of the calendar and of the alarm targets.
  localparam logic [5:0] RST_SEC = 6'h00;
  localparam logic [5:0] RST_MIN = 6'h00;
  localparam logic [4:0] RST_HR = 5'h00;
  localparam logic [2:0] RST_DAY = 3'h1;
  localparam logic [4:0] RST_DATE = 5'h01;
  localparam logic [3:0] RST_MO = 4'h1;
  localparam logic [7:0] RST_YR = 8'h00;
  localparam logic [5:0] RST_TMIN = 6'h00;
  localparam logic [4:0] RST_THR = 5'h00;
  // ==========================================================================
  // Calendar time.
  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] mins;
    logic [4:0] hrs;
    logic [2:0] day;
    logic [4:0] date;
    logic [3:0] mo;
    logic [7:0] yr;
  } rtcsa_time_t;
  localparam rtcsa_time_t RST_TIME = '{RST_SEC, RST_MIN, RST_HR, RST_DAY, RST_DATE, RST_MO, RST_YR};
endpackage

// *** logic/rtcsa_cal.sv ***
// Calendar advance: the time one second later.
// Assumes plain binary fields within their documented ranges.
`timescale 1ns/1ps
`default_nettype none
module rtcsa_cal (
  // Present time
  input wire rtcsa_pkg::rtcsa_time_t cur,
  // Time one second on
  output rtcsa_pkg::rtcsa_time_t nxt,
  // Set when the present time lies outside its valid ranges
  output logic bad
);
  import rtcsa_pkg::*;
  // ==========================================================================
  // Month length
  function automatic logic [4:0] month_days(input logic [3:0] mo, input logic [7:0] yr);
    logic [4:0] d;
    d = 5'd31;
    if (mo == 4'd4 || mo == 4'd6 || mo == 4'd9 || mo == 4'd11) begin
      d = 5'd30;
    end else if (mo == 4'd2) begin
      d = (yr[1:0] == 2'b00) ? 5'd29 : 5'd28;
    end
    return d;
  endfunction
  wire logic [4:0] mdays = month_days(cur.mo, cur.yr);
  wire logic sec_wrap = cur.sec >= 6'd59;
  wire logic min_wrap = sec_wrap && cur.mins >= 6'd59;
  wire logic hr_wrap = min_wrap && cur.hrs >= 5'd23;
  wire logic date_wrap = hr_wrap && cur.date >= mdays;
  wire logic mo_wrap = date_wrap && cur.mo >= 4'd12;
  assign bad = cur.sec > 6'd59 || cur.mins > 6'd59 || cur.hrs > 5'd23 || cur.day == 3'd0
    || cur.date == 5'd0 || cur.date > mdays || cur.mo == 4'd0 || cur.mo > 4'd12
    || cur.yr > 8'd99;
  always_comb begin
    nxt = cur;
    nxt.sec = sec_wrap ? 6'd0 : cur.sec + 6'd1;
    if (sec_wrap) begin
      nxt.mins = min_wrap ? 6'd0 : cur.mins + 6'd1;
    end
    if (min_wrap) begin
      nxt.hrs = hr_wrap ? 5'd0 : cur.hrs + 5'd1;
    end
    if (hr_wrap) begin
      nxt.day = (cur.day >= 3'd7) ? 3'd1 : cur.day + 3'd1;
      nxt.date = date_wrap ? 5'd1 : cur.date + 5'd1;
    end
    if (date_wrap) begin
      nxt.mo = mo_wrap ? 4'd1 : cur.mo + 4'd1;
    end
    if (mo_wrap) begin
      nxt.yr = (cur.yr >= 8'd99) ? 8'd0 : cur.yr + 8'd1;
    end
  end
endmodule
`default_nettype wire

// *** verif/rtcsa_properties.sv ***
// Checker for the clock shadow, alarm and status block.
// Assumes the APB timing of the top module; bound to it at the foot.
`timescale 1ns/1ps
`default_nettype none
module rtcsa_checker
  import rtcsa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  // APB answer and event
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarm_pulse
);
  wire logic mapped;
  wire logic [15:0] idx;
  assign idx = paddr[17:2];
  assign mapped = idx inside {IDX_CTRL, [IDX_SUBSEC:IDX_YR], IDX_TMIN, IDX_THR, IDX_STAT};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Bus answer
  sequence acc_s;
    psel && !penable ##1 psel && penable;
  endsequence
  one_wait_a: assert property (acc_s |=> pready) else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  err_map_a: assert property (acc_s |=> pslverr == !$past(mapped)) else $error("bad pslverr");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("err data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  // ==========================================================================
  // Register content and alarm
  tmin_width_a: assert property (acc_s ##0 !pwrite && idx == IDX_TMIN
    |=> prdata[7:6] == 2'h0) else $error("minutes width");
  thr_width_a: assert property (acc_s ##0 !pwrite && idx == IDX_THR
    |=> prdata[7:5] == 3'h0) else $error("hours width");
  alarm_once_a: assert property (alarm_pulse |=> !alarm_pulse) else $error("long alarm");
endmodule
bind rtcsa_top rtcsa_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_pulse(alarm_pulse));
`default_nettype wire

// *** verif/rtc_shadow_alarm_status_tb_top.sv ***
// Self-checking bench for the clock shadow, alarm and status block.
// Assumes the APB slave answers in its own time; no tick occurs in the run.
`timescale 1ns/1ps
`default_nettype none
module rtc_shadow_alarm_status_tb_top;
  import rtcsa_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, alarm_pulse, er;
  int n_fail = 0, tests_run = 0, n_alarm = 0;
  rtcsa_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_pulse(alarm_pulse));
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (alarm_pulse === 1'b1) n_alarm++;
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic rdc(input logic [15:0] i, input logic [31:0] m, input logic [31:0] e);
    apb(0, i, 8'h0);
    chk(rd & m, e);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (20) @(posedge pclk);
    rdc(IDX_TMIN, 32'hffffffff, 32'h0);
    rdc(IDX_THR, 32'hffffffff, 32'h0);
    rdc(IDX_CTRL, 32'h50, 32'h0);
    chk(32'(n_alarm), 32'h1);
    $display("reset test done");
    apb(1, IDX_TMIN, 8'hff);
    rdc(IDX_TMIN, 32'hffffffff, 32'h3f);
    pstrb <= 4'he;
    apb(1, IDX_TMIN, 8'h05);
    pstrb <= 4'hf;
    rdc(IDX_TMIN, 32'hffffffff, 32'h3f);
    apb(1, IDX_THR, 8'hff);
    rdc(IDX_THR, 32'hffffffff, 32'h1f);
    apb(1, IDX_TMIN, 8'h00);
    repeat (5) @(posedge pclk);
    chk(32'(n_alarm), 32'h1);
    apb(1, IDX_THR, 8'h00);
    repeat (5) @(posedge pclk);
    chk(32'(n_alarm), 32'h2);
    $display("alarm test done");
    rdc(16'h2891, 32'hffffffff, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1, IDX_SUBSEC, 8'h5a);
    rdc(IDX_SUBSEC, 32'hffffffff, 32'h0);
    $display("map test done");
    apb(1, IDX_STAT, 8'h02);
    repeat (5) @(posedge pclk);
    rdc(IDX_CTRL, 32'h10, 32'h10);
    apb(1, IDX_CTRL, 8'h10);
    rdc(IDX_CTRL, 32'h10, 32'h10);
    apb(1, IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 32'h10, 32'h0);
    $display("failure flag test done");
    apb(1, IDX_CTRL, 8'h40);
    rdc(IDX_CTRL, 32'h40, 32'h40);
    apb(1, IDX_SEC, 8'h15);
    rdc(IDX_SEC, 32'hffffffff, 32'h15);
    apb(1, IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 32'h40, 32'h0);
    rdc(IDX_SEC, 32'hffffffff, 32'h0);
    apb(1, IDX_CTRL, 8'h80);
    rdc(IDX_CTRL, 32'h40, 32'h40);
    apb(1, IDX_SEC, 8'h2a);
    rdc(IDX_SEC, 32'hffffffff, 32'h2a);
    apb(1, IDX_HR, 8'h17);
    rdc(IDX_HR, 32'hffffffff, 32'h17);
    apb(1, IDX_CTRL, 8'h00);
    rdc(IDX_SEC, 32'hffffffff, 32'h2a);
    rdc(IDX_CTRL, 32'hc0, 32'h40);
    $display("shadow test done");
    @(posedge pclk);
    presetn <= 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (5) @(posedge pclk);
    rdc(IDX_TMIN, 32'hffffffff, 32'h0);
    rdc(IDX_CTRL, 32'hd0, 32'h0);
    chk(32'(n_alarm), 32'h3);
    $display("second reset test done");
    wrap_up();
  end
  // A whole run takes about 210 cycles, so 20000 leaves a wide margin.
  initial begin
    #160000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
